// File: hw/rst_cfg.svh
// constants for the reset output and development port controller
// assumes a 200 MHz clock and a decoded register write/read port
// Contract
// - control registers clear to defaults when the device enters OFF, except in development mode with reload-on-wake low
// - leave-hibernate clear bit set means register reset on hibernate to active
// - in development mode reload-on-wake low suppresses the clear on entering OFF
// - host reset held low throughout OFF
// - in hibernate host reset follows the host reset hibernate level bit
// - after all supplies reach 90 percent, hold host reset low then release
// - hold selector picks 15, 30, 60 or 120 ms low time for both resets
// - host reset driven low during every shutdown sequence
// - in configuration mode 10 host reset low until crystal valid
// - gpio host reset alternate function mirrors the host reset output
// - memory reset in hibernate follows the memory reset hibernate level bit
// - memory valid cleared at start-up and on memory reset; software sets it
// - manual reset input asserts both resets and nothing else
// - protected reboot bit write of one pulses both resets for hold time
// - reboot acts once address and data arrive, before the acknowledge
// - start-up sequence chosen by configuration pins runs on each off to active
// - development mode routes the 2-wire port to gpio ten and eleven first
// - alternate port select chooses gpio pins or dedicated pins, anytime writable
// - secondary port answers only at fixed address 0x34
// - primary address select gives 0x34, 0x36, 0x3C or 0x3E in development mode
// - custom modes never use secondary port; port controls have no effect
// - reload-on-wake selects register clear in OFF and reload on wake
`ifndef RST_CFG_SVH
`define RST_CFG_SVH

`define RST_OFS_SYS_CTRL_ONE 8'h03
`define RST_OFS_HIB_CTRL 8'h05
`define RST_OFS_IF_CTRL 8'h06

`define RST_BIT_SOFT_REBOOT 14
`define RST_BIT_HOLD_HI 11
`define RST_BIT_HOLD_LO 10
`define RST_BIT_MEM_VALID 5
`define RST_BIT_LEAVE_HIB_CLR 5
`define RST_BIT_HOST_HIB_LVL 4
`define RST_BIT_MEM_HIB_LVL 2
`define RST_BIT_ALT_PORT 15
`define RST_BIT_ADDR_HI 14
`define RST_BIT_ADDR_LO 13
`define RST_BIT_RELOAD_WAKE 11

`define RST_HOLD_SEL_RST 2'h3
`define RST_ALT_PORT_RST 1'h1
`define RST_RELOAD_WAKE_RST 1'h1

`define RST_CFG_DEV 2'h0
`define RST_CFG_XTAL 2'h2

`define RST_ADDR_SECONDARY 7'h34
`define RST_ADDR_P0 7'h34
`define RST_ADDR_P1 7'h36
`define RST_ADDR_P2 7'h3C
`define RST_ADDR_P3 7'h3E

`define RST_CLK_MHZ 200
`define RST_HOLD_BASE_MS 15

`endif

// File: hw/rst_ctrl.sv
// host reset, memory reset and development port control
// assumes power state events arrive as one-cycle pulses from the main sequencer
`timescale 1ns/1ps
`include "rst_cfg.svh"

module rst_ctrl
	import rst_pkg::*;
#(
	parameter int unsigned HOLD_BASE_CYC = `RST_HOLD_BASE_MS * 1000 * `RST_CLK_MHZ
) (
	input wire logic clock,
	input wire logic soft_reboot_cmd,
	input wire logic cfg_pin_hi,
	input wire logic cfg_pin_lo,
	input wire logic ev_startup,
	input wire logic ev_shutdown,
	input wire logic ev_enter_hib,
	input wire logic ev_leave_hib,
	input wire logic supplies_good,
	input wire logic xtal_valid,
	input wire logic mem_rst_from_fsm,
	input wire logic manual_reset_in,
	input wire logic key_unlocked,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic host_reset_n_o,
	output logic host_reset_n_oe,
	output logic gpio_host_reset_n,
	output logic mem_reset_n,
	output logic reg_clear,
	output logic use_secondary_port,
	output logic [6:0] primary_addr,
	output logic [6:0] secondary_addr,
	output logic [1:0] cfg_pin_status
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		rst_state_t st;
		logic [1:0] hold_sel;
		logic mem_valid;
		logic leave_hib_clr;
		logic host_hib_lvl;
		logic mem_hib_lvl;
		logic alt_port_sel;
		logic [1:0] primary_addr_sel;
		logic reload_on_wake;
		logic [31:0] hold_cnt;
		logic reboot_act;
		logic [31:0] reboot_cnt;
		logic host_n;
		logic mem_n;
		logic clr;
		logic [15:0] rdata;
	} rst_regs_t;

	rst_regs_t r_q;
	rst_regs_t r_d;

	logic dev_mode;
	logic [1:0] cfg_mode;

	assign cfg_mode = {cfg_pin_hi, cfg_pin_lo};
	assign dev_mode = (cfg_mode == `RST_CFG_DEV);

	function automatic logic [31:0] hold_cycles(input logic [1:0] sel);
		hold_cycles = HOLD_BASE_CYC << sel;
	endfunction

	function automatic logic [6:0] addr_of(input logic [1:0] sel);
		case (sel)
			2'h0: addr_of = `RST_ADDR_P0;
			2'h1: addr_of = `RST_ADDR_P1;
			2'h2: addr_of = `RST_ADDR_P2;
			default: addr_of = `RST_ADDR_P3;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic do_clear;
		logic wr1;
		logic wr5;
		logic wr6;
		do_clear = 1'b0;
		wr1 = reg_wr && (reg_addr == `RST_OFS_SYS_CTRL_ONE);
		wr5 = reg_wr && (reg_addr == `RST_OFS_HIB_CTRL);
		wr6 = reg_wr && (reg_addr == `RST_OFS_IF_CTRL);
		r_d = r_q;
		r_d.clr = 1'b0;

		// register writes; reboot acts on the write strobe itself
		if (wr1) begin
			r_d.hold_sel = reg_wdata[`RST_BIT_HOLD_HI:`RST_BIT_HOLD_LO];
			r_d.mem_valid = reg_wdata[`RST_BIT_MEM_VALID];
			if (reg_wdata[`RST_BIT_SOFT_REBOOT] && key_unlocked) begin
				r_d.reboot_act = 1'b1;
				r_d.reboot_cnt = hold_cycles(reg_wdata[`RST_BIT_HOLD_HI:`RST_BIT_HOLD_LO]);
			end
		end
		if (wr5) begin
			r_d.leave_hib_clr = reg_wdata[`RST_BIT_LEAVE_HIB_CLR];
			r_d.host_hib_lvl = reg_wdata[`RST_BIT_HOST_HIB_LVL];
			r_d.mem_hib_lvl = reg_wdata[`RST_BIT_MEM_HIB_LVL];
		end
		if (wr6) begin
			r_d.alt_port_sel = reg_wdata[`RST_BIT_ALT_PORT];
			r_d.primary_addr_sel = reg_wdata[`RST_BIT_ADDR_HI:`RST_BIT_ADDR_LO];
			r_d.reload_on_wake = reg_wdata[`RST_BIT_RELOAD_WAKE];
		end

		if (r_q.reboot_act) begin
			if (r_q.reboot_cnt <= 32'h1) begin
				r_d.reboot_act = 1'b0;
			end else begin
				r_d.reboot_cnt = r_q.reboot_cnt - 32'h1;
			end
		end

		// power state tracking
		case (r_q.st)
			RST_ST_OFF: begin
				if (ev_startup) begin
					r_d.st = RST_ST_WAIT_SUP;
				end
			end
			RST_ST_WAIT_SUP: begin
				// crystal check only in mode 10
				if (supplies_good && (cfg_mode != `RST_CFG_XTAL || xtal_valid)) begin
					r_d.st = RST_ST_HOLD;
					r_d.hold_cnt = hold_cycles(r_q.hold_sel);
				end
			end
			RST_ST_HOLD: begin
				if (r_q.hold_cnt <= 32'h1) begin
					r_d.st = RST_ST_ACTIVE;
				end else begin
					r_d.hold_cnt = r_q.hold_cnt - 32'h1;
				end
			end
			RST_ST_ACTIVE: begin
				if (ev_enter_hib) begin
					r_d.st = RST_ST_HIB;
				end
			end
			RST_ST_HIB: begin
				if (ev_leave_hib) begin
					r_d.st = RST_ST_ACTIVE;
					do_clear = r_q.leave_hib_clr;
				end
			end
			default: r_d.st = RST_ST_OFF;
		endcase

		// shutdown from any state but OFF; clear unless development mode holds it off
		if (ev_shutdown && r_q.st != RST_ST_OFF) begin
			r_d.st = RST_ST_OFF;
			if (!dev_mode || r_q.reload_on_wake) begin
				do_clear = 1'b1;
			end
		end

		if (do_clear) begin
			r_d.clr = 1'b1;
			r_d.hold_sel = `RST_HOLD_SEL_RST;
			r_d.mem_valid = 1'b0;
			r_d.leave_hib_clr = 1'b0;
			r_d.host_hib_lvl = 1'b0;
			r_d.mem_hib_lvl = 1'b0;
			r_d.alt_port_sel = `RST_ALT_PORT_RST;
			r_d.primary_addr_sel = 2'h0;
			r_d.reload_on_wake = `RST_RELOAD_WAKE_RST;
			r_d.reboot_act = 1'b0;
		end

		// reset outputs
		case (r_d.st)
			RST_ST_ACTIVE: r_d.host_n = 1'b1;
			RST_ST_HIB: r_d.host_n = r_d.host_hib_lvl;
			default: r_d.host_n = 1'b0;
		endcase
		r_d.mem_n = (r_d.st == RST_ST_HIB) ? r_d.mem_hib_lvl : r_d.host_n;
		if (r_d.reboot_act || manual_reset_in) begin
			r_d.host_n = 1'b0;
			r_d.mem_n = 1'b0;
		end

		// memory valid cleared on start-up and memory reset; set beats nothing
		if ((r_q.st == RST_ST_OFF && ev_startup) || !r_d.mem_n || mem_rst_from_fsm) begin
			r_d.mem_valid = 1'b0;
		end

		// read data
		r_d.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`RST_OFS_SYS_CTRL_ONE: begin
					r_d.rdata[`RST_BIT_HOLD_HI:`RST_BIT_HOLD_LO] = r_q.hold_sel;
					r_d.rdata[`RST_BIT_MEM_VALID] = r_q.mem_valid;
				end
				`RST_OFS_HIB_CTRL: begin
					r_d.rdata[`RST_BIT_LEAVE_HIB_CLR] = r_q.leave_hib_clr;
					r_d.rdata[`RST_BIT_HOST_HIB_LVL] = r_q.host_hib_lvl;
					r_d.rdata[`RST_BIT_MEM_HIB_LVL] = r_q.mem_hib_lvl;
				end
				`RST_OFS_IF_CTRL: begin
					r_d.rdata[`RST_BIT_ALT_PORT] = r_q.alt_port_sel;
					r_d.rdata[`RST_BIT_ADDR_HI:`RST_BIT_ADDR_LO] = r_q.primary_addr_sel;
					r_d.rdata[`RST_BIT_RELOAD_WAKE] = r_q.reload_on_wake;
				end
				default: r_d.rdata = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (soft_reboot_cmd) begin
			r_q <= '0;
			r_q.st <= RST_ST_OFF;
			r_q.hold_sel <= `RST_HOLD_SEL_RST;
			r_q.alt_port_sel <= `RST_ALT_PORT_RST;
			r_q.reload_on_wake <= `RST_RELOAD_WAKE_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = r_q.rdata;
	assign host_reset_n_o = 1'b0;
	assign host_reset_n_oe = !r_q.host_n; // open drain, driven only when low
	assign gpio_host_reset_n = r_q.host_n;
	assign mem_reset_n = r_q.mem_n;
	assign reg_clear = r_q.clr;
	assign use_secondary_port = dev_mode && r_q.alt_port_sel;
	assign primary_addr = dev_mode ? addr_of(r_q.primary_addr_sel) : `RST_ADDR_P0;
	assign secondary_addr = `RST_ADDR_SECONDARY;
	assign cfg_pin_status = cfg_mode;

endmodule

// File: hw/rst_pkg.sv
// types for the reset output and development port controller
// assumes rst_cfg.svh supplies all numeric constants
package rst_pkg;

	typedef enum logic [4:0] {
		RST_ST_OFF = 5'b00001,
		RST_ST_WAIT_SUP = 5'b00010,
		RST_ST_HOLD = 5'b00100,
		RST_ST_ACTIVE = 5'b01000,
		RST_ST_HIB = 5'b10000
	} rst_state_t;

endpackage

// File: test/rst_ctrl_bench.sv
// self-checking bench for rst_ctrl
// assumes the monitor is bound in and straps tie to development mode
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module rst_ctrl_bench;
	logic clock = 0, soft_reboot_cmd = 1, cfg_pin_hi = 0, cfg_pin_lo = 0, supplies_good = 0;
	logic xtal_valid = 0, ev_startup = 0, ev_shutdown = 0, ev_enter_hib = 0, ev_leave_hib = 0;
	logic mem_rst_from_fsm = 0, manual_reset_in = 0, key_unlocked = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic host_reset_n_o, host_reset_n_oe, gpio_host_reset_n, mem_reset_n, reg_clear;
	logic use_secondary_port, host_pin, s;
	logic [6:0] primary_addr, secondary_addr;
	logic [1:0] cfg_pin_status;
	int n_fail = 0, checks = 0, n;
	logic [39:0] rows [5] = '{{8'h03, 16'h0C20, 16'h0C20}, {8'h05, 16'h0034, 16'h0034},
		{8'h06, 16'hE800, 16'hE800}, {8'h07, 16'hFFFF, 16'h0000}, {8'h03, 16'h4000, 16'h0000}};
	logic [6:0] pa [4] = '{7'h34, 7'h36, 7'h3C, 7'h3E};
	always #2.5 clock = ~clock;
	rst_ctrl #(.HOLD_BASE_CYC(8)) i_rst_ctrl (.*);
	rst_host_model i_rst_host_model (.host_reset_n_oe(host_reset_n_oe), .host_pin(host_pin));
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'h0;
		@(negedge clock);
		`CHK(reg_rdata, e)
	endtask
	task pl(input int k);
		@(posedge clock);
		{ev_leave_hib, ev_enter_hib, ev_shutdown, ev_startup} <= 4'h1 << k;
		@(posedge clock);
		{ev_leave_hib, ev_enter_hib, ev_shutdown, ev_startup} <= 4'h0;
	endtask
	task rel();
		n = 0;
		while (host_reset_n_oe !== 1'h0 && n < 2000) begin
			@(negedge clock);
			n++;
		end
	endtask
	task clr();
		s = 0;
		repeat (4) begin
			@(negedge clock);
			if (reg_clear === 1'h1) s = 1;
		end
	endtask
	task conclude();
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	// ----------------------------------------
	// main sequence, straps at 00
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		soft_reboot_cmd <= 1'h0;
		rd(8'h03, 16'h0C00);
		rd(8'h06, 16'h8800);
		`CHK(use_secondary_port, 1'h1)
		`CHK(host_reset_n_oe, 1'h1)
		supplies_good <= 1'h1;
		pl(0);
		rel();
		`CHK(n inside {[63:68]}, 1'h1)
		`CHK(host_pin, 1'h1)
		for (int i = 0; i < 5; i++) begin
			wr(rows[i][39:32], rows[i][31:16]);
			rd(rows[i][39:32], rows[i][15:0]);
		end
		`CHK(host_reset_n_oe, 1'h0)
		for (int i = 0; i < 4; i++) begin
			wr(8'h06, {1'h1, 2'(i), 13'h0800});
			@(negedge clock);
			`CHK(primary_addr, pa[i])
		end
		wr(8'h06, 16'h0800);
		@(negedge clock);
		`CHK(use_secondary_port, 1'h0)
		wr(8'h03, 16'h0020);
		mem_rst_from_fsm <= 1'h1;
		rd(8'h03, 16'h0000);
		mem_rst_from_fsm <= 1'h0;
		rel();
		key_unlocked <= 1'h1;
		wr(8'h03, 16'h4000);
		@(negedge clock);
		`CHK({host_reset_n_oe, mem_reset_n, gpio_host_reset_n}, 3'h4)
		rel();
		`CHK(n inside {[6:10]}, 1'h1)
		@(posedge clock) manual_reset_in <= 1'h1;
		repeat (2) @(negedge clock);
		`CHK({host_reset_n_oe, mem_reset_n}, 2'h2)
		@(posedge clock) manual_reset_in <= 1'h0;
		rel();
		rd(8'h05, 16'h0034);
		pl(2);
		repeat (3) @(negedge clock);
		`CHK({host_reset_n_oe, mem_reset_n}, 2'h1)
		pl(3);
		clr();
		`CHK(s, 1'h1)
		rd(8'h05, 16'h0000);
		wr(8'h06, 16'h0000);
		pl(1);
		clr();
		`CHK(s, 1'h0)
		`CHK(host_reset_n_oe, 1'h1)
		rd(8'h06, 16'h0000);
		pl(0);
		rel();
		wr(8'h06, 16'h0800);
		pl(1);
		clr();
		`CHK(s, 1'h1)
		rd(8'h06, 16'h8800);
		conclude();
	end
endmodule

// File: test/rst_ctrl_monitor.sv
// port checker for the reset and port controller
// assumes binding into rst_ctrl, one clock domain
`timescale 1ns/1ps
module rst_ctrl_monitor #(
	parameter int unsigned HOLD_BASE_CYC = 8
) (
	input wire logic clock,
	input wire logic soft_reboot_cmd,
	input wire logic cfg_pin_hi,
	input wire logic cfg_pin_lo,
	input wire logic manual_reset_in,
	input wire logic key_unlocked,
	input wire logic ev_shutdown,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic host_reset_n_o,
	input wire logic host_reset_n_oe,
	input wire logic gpio_host_reset_n,
	input wire logic mem_reset_n,
	input wire logic use_secondary_port,
	input wire logic [6:0] primary_addr,
	input wire logic [6:0] secondary_addr
);
	logic [15:0] wd_q;
	logic dev;
	assign dev = !cfg_pin_hi && !cfg_pin_lo;
	always_ff @(posedge clock) wd_q <= reg_wdata;
	default clocking @(posedge clock); endclocking
	default disable iff (soft_reboot_cmd);
	property p_mr; manual_reset_in |-> ##[1:2] (host_reset_n_oe && !mem_reset_n); endproperty
	a_mr: assert property (p_mr) else $error("manual reset ignored");
	property p_gpio; gpio_host_reset_n == !host_reset_n_oe; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio reset differs");
	property p_od; host_reset_n_o == 1'h0; endproperty
	a_od: assert property (p_od) else $error("reset pin drives high");
	property p_sec; secondary_addr == 7'h34; endproperty
	a_sec: assert property (p_sec) else $error("secondary address wrong");
	property p_boot; reg_wr && reg_addr == 8'h03 && reg_wdata[14] && key_unlocked
		|=> host_reset_n_oe && !mem_reset_n; endproperty
	a_boot: assert property (p_boot) else $error("reboot ignored");
	property p_off; ev_shutdown |=> host_reset_n_oe; endproperty
	a_off: assert property (p_off) else $error("shutdown left reset high");
	property p_port; dev && reg_wr && reg_addr == 8'h06 |=> use_secondary_port == wd_q[15];
	endproperty
	a_port: assert property (p_port) else $error("port select wrong");
	property p_addr; dev && reg_wr && reg_addr == 8'h06
		|=> primary_addr == (7'h34 | {3'h0, wd_q[14], 1'h0, wd_q[13], 1'h0}); endproperty
	a_addr: assert property (p_addr) else $error("primary address wrong");
endmodule
bind rst_ctrl rst_ctrl_monitor #(.HOLD_BASE_CYC(HOLD_BASE_CYC)) i_rst_ctrl_monitor (.*);

// File: test/rst_host_model.sv
// host side of the reset net
// assumes a pull-up on the open-drain reset line
`timescale 1ns/1ps
module rst_host_model (
	input wire logic host_reset_n_oe,
	output logic host_pin
);
	assign host_pin = host_reset_n_oe ? 1'h0 : 1'h1;
endmodule
